// ### design/msc_startup_cfg.sv
// module: startup configuration word register with decoded start settings
//
// Notes on behaviour
// - bit 31 is a read/write parity bit, reset zero, stored only.
// - bits 30:29 pick single align, double align, position probe or slow first cycle.
// - bits 28:25 pick current ramp 0.1 to 5000 A/s; code f means no limit.
// - bits 24:21 pick align time, 10 ms up to 10 s.
// - bits 20:17 pick align or slow-cycle current cap, 0.125 to 8.0 A.
// - bits 16:14 pick position probe tick rate, 50 to 10000 Hz.
`timescale 1ns/10ps
module msc_startup_cfg (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [31:0] startup_config_word_o,
    output logic [1:0] start_method_select_o,
    output logic [15:0] ramp_rate_o,
    output logic ramp_unlimited_o,
    output logic [13:0] align_time_ms_o,
    output logic [13:0] start_phase_current_cap_o,
    output logic [13:0] position_probe_tick_rate_o,
    output logic probe_selected_o
);
    // ==========================================================
    // register bank
    logic [31:0] cfg_q;
    logic [31:0] rdata_q;
    wire cfg_hit = (addr_i == msc_pkg::CFG_WORD_OFS);
    wire sts_hit = (addr_i == msc_pkg::STATUS_OFS);
    wire cfg_wr = wr_i && cfg_hit;
    wire [31:0] cfg_d = cfg_wr ? wdata_i : cfg_q;
    msc_cfg_if cfg_bus ();
    assign cfg_bus.word = cfg_q;
    msc_field_decode u_decode (
        .cfg(cfg_bus)
    );
    // status: method code and unlimited flag as decoded now
    wire [31:0] sts_word = {29'h0, cfg_bus.no_limit, cfg_bus.method};
    wire [31:0] rd_mux = cfg_hit ? cfg_q : (sts_hit ? sts_word : msc_pkg::BAD_ADDR_DATA);

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_q <= msc_pkg::CFG_WORD_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_q;

    // ==========================================================
    // registered decoded outputs, one cycle behind the word
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // reset values are the decode of the all-zero reset word
            startup_config_word_o <= msc_pkg::CFG_WORD_RST;
            start_method_select_o <= msc_pkg::MSC_SINGLE_ALIGN;
            ramp_rate_o <= msc_pkg::RAMP_TBL[0];
            ramp_unlimited_o <= 1'b0;
            align_time_ms_o <= msc_pkg::ALIGN_TBL[0];
            start_phase_current_cap_o <= msc_pkg::ILIM_TBL[0];
            position_probe_tick_rate_o <= msc_pkg::PROBE_TBL[0];
            probe_selected_o <= 1'b0;
        end else begin
            startup_config_word_o <= cfg_q;
            start_method_select_o <= cfg_bus.method;
            ramp_rate_o <= cfg_bus.ramp;
            ramp_unlimited_o <= cfg_bus.no_limit;
            align_time_ms_o <= cfg_bus.align_ms;
            start_phase_current_cap_o <= cfg_bus.ilim_ma;
            position_probe_tick_rate_o <= cfg_bus.probe_hz;
            probe_selected_o <= (cfg_bus.method == msc_pkg::MSC_POSITION_PROBE);
        end
    end

    // ==========================================================
    // checks
    sequence s_cfg_write;
        wr_i && cfg_hit;
    endsequence
    // no disable on these: they look at the reset values themselves
    sequence s_in_reset;
        !nrst_i;
    endsequence
    chk_parity_write: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write |=> cfg_q[msc_pkg::PARITY_BIT] == $past(wdata_i[31]))
        else $error("parity bit not stored");
    chk_word_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !cfg_wr |=> $stable(cfg_q)) else $error("config word changed without write");
    chk_word_copy: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write |=> ##1 startup_config_word_o == $past(wdata_i, 2))
        else $error("word copy does not follow write");
    chk_method_sel: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write |=> ##1 start_method_select_o == $past(wdata_i[30:29], 2))
        else $error("start method not decoded");
    chk_probe_flag: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write |=> ##1 probe_selected_o == ($past(wdata_i[30:29], 2) == 2'h2))
        else $error("probe flag disagrees with written method");

    // ==========================================================
    // reset values, seen at the edge after a low sample of reset
    chk_reset_word: assert property (@(posedge clock_i)
        s_in_reset |=> cfg_q == 32'h0000_0000 && startup_config_word_o == 32'h0000_0000)
        else $error("word not cleared by reset");
    chk_reset_method: assert property (@(posedge clock_i)
        s_in_reset |=> start_method_select_o == 2'h0 && !probe_selected_o)
        else $error("method not cleared by reset");
    chk_reset_ramp: assert property (@(posedge clock_i)
        s_in_reset |=> ramp_rate_o == 16'h0001 && !ramp_unlimited_o)
        else $error("ramp not at code zero after reset");
    chk_reset_align: assert property (@(posedge clock_i)
        s_in_reset |=> align_time_ms_o == 14'h000a)
        else $error("align time not at code zero after reset");
    chk_reset_cap: assert property (@(posedge clock_i)
        s_in_reset |=> start_phase_current_cap_o == 14'h007d)
        else $error("current cap not at code zero after reset");
    chk_reset_rate: assert property (@(posedge clock_i)
        s_in_reset |=> position_probe_tick_rate_o == 14'h0032 && rdata_o == 32'h0000_0000)
        else $error("probe rate or read data not cleared by reset");

    // ==========================================================
    // ramp table: code f is the only one without a limit
    chk_ramp_unlim: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[28:25] == 4'hf |=> ##1 ramp_unlimited_o)
        else $error("code f not unlimited");
    chk_ramp_limited: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[28:25] != 4'hf |=> ##1 !ramp_unlimited_o)
        else $error("limited code flagged unlimited");
    chk_ramp_min: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[28:25] == 4'h0 |=> ##1 ramp_rate_o == 16'h0001)
        else $error("lowest ramp wrong");
    chk_ramp_one: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[28:25] == 4'h1 |=> ##1 ramp_rate_o == 16'h000a)
        else $error("code 1 ramp wrong");
    chk_ramp_mid: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[28:25] == 4'h7 |=> ##1 ramp_rate_o == 16'h03e8)
        else $error("code 7 ramp wrong");
    chk_ramp_high: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[28:25] == 4'hb |=> ##1 ramp_rate_o == 16'h1388)
        else $error("code b ramp wrong");
    chk_ramp_top: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[28:25] == 4'he |=> ##1 ramp_rate_o == 16'hc350)
        else $error("code e ramp wrong");

    // ==========================================================
    // align time table, in ms
    chk_align_min: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[24:21] == 4'h0 |=> ##1 align_time_ms_o == 14'h000a)
        else $error("shortest align time wrong");
    chk_align_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[24:21] == 4'h7 |=> ##1 align_time_ms_o == 14'h02ee)
        else $error("code 7 align time wrong");
    chk_align_second: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[24:21] == 4'h8 |=> ##1 align_time_ms_o == 14'h03e8)
        else $error("code 8 align time wrong");
    chk_align_long: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[24:21] == 4'he |=> ##1 align_time_ms_o == 14'h1d4c)
        else $error("code e align time wrong");
    chk_align_max: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[24:21] == 4'hf |=> ##1 align_time_ms_o == 14'h2710)
        else $error("longest align time wrong");

    // ==========================================================
    // current cap table, in mA; the top two codes leave the half-amp steps
    chk_ilim_min: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[20:17] == 4'h0 |=> ##1 start_phase_current_cap_o == 14'h007d)
        else $error("lowest current cap wrong");
    chk_ilim_half: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[20:17] == 4'h2 |=> ##1 start_phase_current_cap_o == 14'h01f4)
        else $error("code 2 current cap wrong");
    chk_ilim_amp: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[20:17] == 4'h3 |=> ##1 start_phase_current_cap_o == 14'h03e8)
        else $error("code 3 current cap wrong");
    chk_ilim_six: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[20:17] == 4'hd |=> ##1 start_phase_current_cap_o == 14'h1770)
        else $error("code d current cap wrong");
    chk_ilim_top: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[20:17] == 4'he |=> ##1 start_phase_current_cap_o == 14'h1b58)
        else $error("code e current cap wrong");
    chk_ilim_max: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[20:17] == 4'hf |=> ##1 start_phase_current_cap_o == 14'h1f40)
        else $error("code f current cap wrong");

    // ==========================================================
    // probe tick rate table, in Hz
    chk_probe_slow: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[16:14] == 3'h0 |=> ##1 position_probe_tick_rate_o == 14'h0032)
        else $error("slowest probe rate wrong");
    chk_probe_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[16:14] == 3'h2 |=> ##1 position_probe_tick_rate_o == 14'h00fa)
        else $error("code 2 probe rate wrong");
    chk_probe_one_khz: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[16:14] == 3'h4 |=> ##1 position_probe_tick_rate_o == 14'h03e8)
        else $error("code 4 probe rate wrong");
    chk_probe_five_khz: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[16:14] == 3'h6 |=> ##1 position_probe_tick_rate_o == 14'h1388)
        else $error("code 6 probe rate wrong");
    chk_probe_rate: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_cfg_write ##0 wdata_i[16:14] == 3'h7 |=> ##1 position_probe_tick_rate_o == 14'h2710)
        else $error("fastest probe rate wrong");

    // ==========================================================
    // register port answers; read data is zero outside its one cycle
    // so that a late sampler sees a clear miss rather than stale data
    chk_read_timing: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rd_i && cfg_hit && !wr_i |=> rdata_o == cfg_q) else $error("read data late");
    chk_status_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rd_i && sts_hit |=> rdata_o == {29'h0, ($past(cfg_q[28:25]) == 4'hf), $past(cfg_q[30:29])})
        else $error("status read wrong");
    chk_unmapped_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        rd_i && !cfg_hit && !sts_hit |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_read_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data stands without a read");
endmodule

// ### design/msc_pkg.sv
// package: register map, field layout and decode tables of the startup configuration word
package msc_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] CFG_WORD_OFS = 8'h84;
    localparam logic [7:0] STATUS_OFS = 8'h88;
    localparam logic [31:0] CFG_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
    // ==========================================================
    // field positions
    localparam int PARITY_BIT = 31;
    localparam int METHOD_LSB = 29;
    localparam int RAMP_LSB = 25;
    localparam int ALIGN_LSB = 21;
    localparam int ILIM_LSB = 17;
    localparam int PROBE_LSB = 14;
    localparam logic [3:0] RAMP_NO_LIMIT = 4'hf;
    // ==========================================================
    // start methods
    typedef enum logic [1:0] {
        MSC_SINGLE_ALIGN,
        MSC_DOUBLE_ALIGN,
        MSC_POSITION_PROBE,
        MSC_SLOW_FIRST_CYCLE
    } msc_method_t;
    // ==========================================================
    // decode tables: ramp in 0.1 A/s, time in ms, current in mA, rate in Hz
    localparam logic [15:0] RAMP_TBL [16] = '{16'h0001, 16'h000a, 16'h0032, 16'h0064,
        16'h0096, 16'h00fa, 16'h01f4, 16'h03e8, 16'h05dc, 16'h07d0, 16'h09c4,
        16'h1388, 16'h2710, 16'h4e20, 16'hc350, 16'h0000};
    localparam logic [13:0] ALIGN_TBL [16] = '{14'h000a, 14'h0032, 14'h0064, 14'h00c8,
        14'h012c, 14'h0190, 14'h01f4, 14'h02ee, 14'h03e8, 14'h05dc, 14'h07d0,
        14'h0bb8, 14'h0fa0, 14'h1388, 14'h1d4c, 14'h2710};
    localparam logic [13:0] ILIM_TBL [16] = '{14'h007d, 14'h00fa, 14'h01f4, 14'h03e8,
        14'h05dc, 14'h07d0, 14'h09c4, 14'h0bb8, 14'h0dac, 14'h0fa0, 14'h1194,
        14'h1388, 14'h157c, 14'h1770, 14'h1b58, 14'h1f40};
    localparam logic [13:0] PROBE_TBL [8] = '{14'h0032, 14'h0064, 14'h00fa, 14'h01f4,
        14'h03e8, 14'h07d0, 14'h1388, 14'h2710};
endpackage

// ### design/msc_cfg_if.sv
// interface: config word passed from the register bank to the decoder, decoded start settings passed back
`timescale 1ns/10ps
interface msc_cfg_if;
    logic [31:0] word;
    msc_pkg::msc_method_t method;
    logic [15:0] ramp;
    logic no_limit;
    logic [13:0] align_ms;
    logic [13:0] ilim_ma;
    logic [13:0] probe_hz;
    modport src (output word, input method, ramp, no_limit, align_ms, ilim_ma, probe_hz);
    modport dec (input word, output method, ramp, no_limit, align_ms, ilim_ma, probe_hz);
endinterface

// ### design/msc_field_decode.sv
// module: combinational lookup of the start fields into physical values
`timescale 1ns/10ps
module msc_field_decode (
    msc_cfg_if.dec cfg
);
    // ==========================================================
    // field slices
    wire [1:0] method_code = cfg.word[msc_pkg::METHOD_LSB +: 2];
    wire [3:0] ramp_code = cfg.word[msc_pkg::RAMP_LSB +: 4];
    wire [3:0] align_code = cfg.word[msc_pkg::ALIGN_LSB +: 4];
    wire [3:0] ilim_code = cfg.word[msc_pkg::ILIM_LSB +: 4];
    wire [2:0] probe_code = cfg.word[msc_pkg::PROBE_LSB +: 3];
    assign cfg.method = msc_pkg::msc_method_t'(method_code);
    assign cfg.ramp = msc_pkg::RAMP_TBL[ramp_code];
    // top code means unlimited; table holds zero there
    assign cfg.no_limit = (ramp_code == msc_pkg::RAMP_NO_LIMIT);
    assign cfg.align_ms = msc_pkg::ALIGN_TBL[align_code];
    assign cfg.ilim_ma = msc_pkg::ILIM_TBL[ilim_code];
    assign cfg.probe_hz = msc_pkg::PROBE_TBL[probe_code];
endmodule

// ### tb/msc_startup_cfg_tb.sv
// testbench: register access and field decode of the startup configuration word
`timescale 1ns/10ps
module msc_startup_cfg_tb;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o, word_o, w;
    logic [1:0] method_o;
    logic [15:0] ramp_o;
    logic unl_o, probe_o;
    logic rd_pend = 1'b0;
    logic [13:0] align_o, cap_o, rate_o;
    logic [31:0] model_q;
    logic [31:0] exp_q [$];
    int err_count = 0;
    int n_tests = 0;
    int ramp_t [16] = '{1, 10, 50, 100, 150, 250, 500, 1000, 1500, 2000, 2500, 5000, 10000,
        20000, 50000, 0};
    int align_t [16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 1500, 2000, 3000, 4000,
        5000, 7500, 10000};
    int cap_t [16] = '{125, 250, 500, 1000, 1500, 2000, 2500, 3000, 3500, 4000, 4500, 5000,
        5500, 6000, 7000, 8000};
    int rate_t [8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};
    msc_startup_cfg uut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .startup_config_word_o(word_o),
        .start_method_select_o(method_o), .ramp_rate_o(ramp_o), .ramp_unlimited_o(unl_o),
        .align_time_ms_o(align_o), .start_phase_current_cap_o(cap_o),
        .position_probe_tick_rate_o(rate_o), .probe_selected_o(probe_o));
    // ==========================================================
    // clock, checking and closing
    always #2 clock_i = ~clock_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clock_i) rd_pend <= rd_i & nrst_i;
    always @(negedge clock_i) begin
        if (rd_pend) check(rdata_o, exp_q.pop_front());
        else check(rdata_o, 32'h0000_0000);
    end
    // ==========================================================
    // bus driver: the model and the queue follow every strobe
    task automatic op(input logic wr, input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= wr;
        rd_i <= rd;
        addr_i <= a;
        wdata_i <= d;
        if (wr && a == msc_pkg::CFG_WORD_OFS) model_q = d;
        if (rd) exp_q.push_back(a == msc_pkg::CFG_WORD_OFS ? model_q :
            a == msc_pkg::STATUS_OFS ? {29'h0, model_q[28:25] == 4'hf, model_q[30:29]} : 32'h0);
    endtask
    // two idle edges let the decoded outputs settle after a write
    task automatic dchk();
        op(1'b0, 1'b0, 8'h00, 32'h0);
        op(1'b0, 1'b0, 8'h00, 32'h0);
        @(negedge clock_i);
        check(word_o, model_q);
        check({30'h0, method_o}, {30'h0, model_q[30:29]});
        check({31'h0, probe_o}, {31'h0, model_q[30:29] == 2'h2});
        check({16'h0, ramp_o}, ramp_t[model_q[28:25]]);
        check({31'h0, unl_o}, {31'h0, model_q[28:25] == 4'hf});
        check({18'h0, align_o}, align_t[model_q[24:21]]);
        check({18'h0, cap_o}, cap_t[model_q[20:17]]);
        check({18'h0, rate_o}, rate_t[model_q[16:14]]);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        model_q = 32'h0;
        void'($urandom(32'hee44dfc1));
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        dchk();
        op(1'b0, 1'b1, msc_pkg::CFG_WORD_OFS, 32'h0);
        for (int i = 0; i < 16; i++) begin
            w = {i[0], i[1:0], i[3:0], i[3:0], i[3:0], i[2:0], 14'($urandom())};
            op(1'b1, 1'b0, msc_pkg::CFG_WORD_OFS, w);
            op(1'b0, 1'b1, msc_pkg::CFG_WORD_OFS, 32'h0);
            op(1'b1, 1'b0, msc_pkg::STATUS_OFS, $urandom());
            op(1'b0, 1'b1, msc_pkg::STATUS_OFS, 32'h0);
            op(1'b1, 1'b0, 8'h00, $urandom());
            op(1'b0, 1'b1, 8'h00, 32'h0);
            dchk();
        end
        // second reset in mid-run must clear the word and every decode
        @(posedge clock_i);
        nrst_i <= 1'b0;
        @(posedge clock_i);
        nrst_i <= 1'b1;
        model_q = 32'h0;
        dchk();
        op(1'b0, 1'b1, msc_pkg::CFG_WORD_OFS, 32'h0);
        op(1'b0, 1'b0, 8'h00, 32'h0);
        op(1'b0, 1'b0, 8'h00, 32'h0);
        end_sim();
    end
    // tests need well under a thousand cycles
    initial begin
        #20000;
        err_count++;
        end_sim();
    end
endmodule
